// File: common/lep_pkg.sv
// constants, codes and state types of the lookup engine policy registers
package lep_pkg;
    // ==========================================================
    // register map: indices, byte address is four times the index
    localparam int unsigned ADDR_W = 12;
    localparam logic [9:0] IDX_CTL1 = 10'h311;
    localparam logic [9:0] IDX_CTL2 = 10'h312;
    localparam logic [9:0] IDX_CTL3 = 10'h313;
    // ==========================================================
    // field positions
    localparam int unsigned C1_FLUSH_ALL = 5;
    localparam int unsigned C1_FLUSH_STP = 4;
    localparam int unsigned C1_AGE_EN = 2;
    localparam int unsigned C2_TRAP = 6;
    localparam int unsigned C2_DYN_FILT = 5;
    localparam int unsigned C2_STA_FILT = 4;
    localparam int unsigned C2_SCOPE_LSB = 2;
    localparam int unsigned C2_PRIO_LSB = 0;
    // ==========================================================
    // values after reset, and the writable bit mask of control register 1
    localparam logic [7:0] CTL1_RST = 8'h04;
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [7:0] CTL3_RST = 8'h4B;
    localparam logic [7:0] CTL1_MASK = 8'h34;
    // ==========================================================
    // codes of the flush scope and priority source fields
    localparam logic [1:0] SCOPE_NONE = 2'h0;
    localparam logic [1:0] SCOPE_DYN = 2'h1;
    localparam logic [1:0] SCOPE_STA = 2'h2;
    localparam logic [1:0] SCOPE_BOTH = 2'h3;
    localparam logic [1:0] PSRC_DA = 2'h0;
    localparam logic [1:0] PSRC_SA = 2'h1;
    localparam logic [1:0] PSRC_MAX = 2'h2;
    localparam logic [1:0] PSRC_MIN = 2'h3;
    // ==========================================================
    // timing: age period unit is one second
    localparam int unsigned AGE_UNIT_S = 1;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SEC_CYCLES = AGE_UNIT_S * CLK_HZ;
    // ==========================================================
    // datapath widths, host port map and flush sequencer state type
    localparam int unsigned NPORT = 3;
    localparam int unsigned PRIO_W = 3;
    localparam logic [NPORT-1:0] HOST_MAP = 3'h4;
    typedef enum logic [0:0] {
        FL_IDLE = 1'b0,
        FL_BUSY = 1'b1
    } lep_flush_st_t;
endpackage

// File: common/lep_cfg_if.sv
// settings carried from the register file to the datapath helpers
`timescale 1ns/1ns
interface lep_cfg_if;
    logic mc_trap;
    logic dyn_filt;
    logic sta_filt;
    logic [1:0] prio_sel;
    logic age_en;
    logic [7:0] age_period;
    modport src(output mc_trap, dyn_filt, sta_filt, prio_sel, age_en,
        age_period);
    modport fwd(input mc_trap, dyn_filt, sta_filt, prio_sel);
    modport age(input age_en, age_period);
endinterface

// File: hdl/lep_fwd_sel.sv
// egress map and address based priority selection for one lookup
`timescale 1ns/1ns
module lep_fwd_sel #(
    parameter int unsigned NPORT = lep_pkg::NPORT,
    parameter int unsigned PRIO_W = lep_pkg::PRIO_W,
    parameter logic [NPORT-1:0] HOST_MAP = lep_pkg::HOST_MAP
) (
    input wire logic pclk,
    input wire logic presetn,
    lep_cfg_if.fwd cfg,
    input wire logic lk_valid,
    input wire logic lk_hit,
    input wire logic lk_static,
    input wire logic lk_rsv_mcast,
    input wire logic dbl_tag_en,
    input wire logic [NPORT-1:0] lk_entry_map,
    input wire logic [NPORT-1:0] lk_vlan_map,
    input wire logic [PRIO_W-1:0] lk_da_prio,
    input wire logic [PRIO_W-1:0] lk_sa_prio,
    output logic fwd_valid,
    output logic [NPORT-1:0] fwd_map,
    output logic [PRIO_W-1:0] address_based_priority
);
    function automatic logic [PRIO_W-1:0] pick_prio(
        input logic [1:0] sel,
        input logic [PRIO_W-1:0] da,
        input logic [PRIO_W-1:0] sa);
        unique case (sel)
            lep_pkg::PSRC_DA: pick_prio = da;
            lep_pkg::PSRC_SA: pick_prio = sa;
            lep_pkg::PSRC_MAX: pick_prio = (da > sa) ? da : sa;
            lep_pkg::PSRC_MIN: pick_prio = (da < sa) ? da : sa;
        endcase
    endfunction

    logic filt;
    logic [NPORT-1:0] map_next;
    // a miss is flooded within the vlan
    always_comb begin
        filt = lk_static ? cfg.sta_filt : cfg.dyn_filt;
        if (lk_rsv_mcast && dbl_tag_en && cfg.mc_trap) begin
            map_next = HOST_MAP;
        end else if (lk_hit) begin
            map_next = filt ? (lk_entry_map & lk_vlan_map) : lk_entry_map;
        end else begin
            map_next = lk_vlan_map;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_valid <= 1'b0;
            fwd_map <= '0;
            address_based_priority <= '0;
        end else begin
            fwd_valid <= lk_valid;
            if (lk_valid) begin
                fwd_map <= map_next;
                address_based_priority <= pick_prio(cfg.prio_sel,
                    lk_da_prio, lk_sa_prio);
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_trap_host_only: assert property (
        lk_valid && lk_rsv_mcast && dbl_tag_en && cfg.mc_trap
        |=> fwd_valid && fwd_map == HOST_MAP)
        else $error("trapped multicast not sent to host only");
    a_dyn_filter_and: assert property (
        lk_valid && lk_hit && !lk_static && !lk_rsv_mcast
        |=> fwd_map == ($past(cfg.dyn_filt)
            ? $past(lk_entry_map & lk_vlan_map) : $past(lk_entry_map)))
        else $error("dynamic hit map wrong");
    a_sta_filter_and: assert property (
        lk_valid && lk_hit && lk_static && !lk_rsv_mcast
        |=> fwd_map == ($past(cfg.sta_filt)
            ? $past(lk_entry_map & lk_vlan_map) : $past(lk_entry_map)))
        else $error("static hit map wrong");
    a_prio_bounds: assert property (
        lk_valid && cfg.prio_sel == lep_pkg::PSRC_MAX
        |=> address_based_priority >= $past(lk_da_prio)
            && address_based_priority >= $past(lk_sa_prio))
        else $error("higher priority not chosen");
    a_prio_source: assert property (
        lk_valid && cfg.prio_sel == lep_pkg::PSRC_SA
        |=> address_based_priority == $past(lk_sa_prio))
        else $error("source lookup priority not chosen");
    c_trap: cover property (lk_valid && lk_rsv_mcast && dbl_tag_en
        && cfg.mc_trap);
    c_min_prio: cover property (lk_valid && lk_da_prio != lk_sa_prio
        && cfg.prio_sel == lep_pkg::PSRC_MIN);
endmodule

// File: hdl/lep_age_tick.sv
// aging period timer: one pulse per age period while aging is on
`timescale 1ns/1ns
module lep_age_tick #(
    parameter int unsigned SEC_CYCLES = lep_pkg::SEC_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    lep_cfg_if.age cfg,
    output logic age_tick
);
    localparam int unsigned CW = $clog2(SEC_CYCLES + 1);
    localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYCLES - 1);
    logic [CW-1:0] cyc_reg;
    logic [7:0] sec_reg;
    logic sec_pulse;

    assign sec_pulse = cfg.age_en && (cyc_reg == SEC_LAST);

    // one second divider, cleared while aging is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_reg <= '0;
        end else if (!cfg.age_en || sec_pulse) begin
            cyc_reg <= '0;
        end else begin
            cyc_reg <= cyc_reg + 1'b1;
        end
    end

    // period of zero seconds gives no aging at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_reg <= 8'h00;
            age_tick <= 1'b0;
        end else begin
            age_tick <= 1'b0;
            if (!cfg.age_en) begin
                sec_reg <= 8'h00;
            end else if (sec_pulse) begin
                if (sec_reg + 8'h01 >= cfg.age_period
                        && cfg.age_period != 8'h00) begin
                    sec_reg <= 8'h00;
                    age_tick <= 1'b1;
                end else begin
                    sec_reg <= sec_reg + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_age_gated: assert property (
        !$past(cfg.age_en) |-> !age_tick)
        else $error("aging tick while aging disabled");
    a_age_on_second: assert property (
        age_tick |-> $past(sec_pulse))
        else $error("aging tick off a second boundary");
    c_age_tick: cover property (age_tick);
endmodule

// File: hdl/lep_regs_top.sv
// lookup engine policy registers with apb slave, flush and aging control
// Operation
// - trap bit with double tagging sends reserved multicast to host only
// - dynamic hit map ANDed with vlan map when dynamic filter set
// - static hit map ANDed with vlan map when static filter set
// - both egress filter bits reset to zero
// - flush scope 01 dynamic, 10 static, 11 both entries
// - scope 00 means no flush; hardware shows 00 when done
// - priority source 00 from destination, 01 from source lookup
// - priority source 10 takes higher, 11 takes lower priority
// - dynamic entries age after period seconds times age count
// - age period resets to 4B and ages dynamic entries only
// - whole table flush trigger self clears, flushes entries of the flush scope
// - spanning tree flush trigger flushes matching entries, self clears
// - aging only while aging enable set, which resets to one
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module lep_regs_top #(
    parameter int unsigned SEC_CYCLES = lep_pkg::SEC_CYCLES,
    parameter int unsigned NPORT = lep_pkg::NPORT,
    parameter int unsigned PRIO_W = lep_pkg::PRIO_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lep_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lk_valid,
    input wire logic lk_hit,
    input wire logic lk_static,
    input wire logic lk_rsv_mcast,
    input wire logic dbl_tag_en,
    input wire logic [NPORT-1:0] lk_entry_map,
    input wire logic [NPORT-1:0] lk_vlan_map,
    input wire logic [PRIO_W-1:0] lk_da_prio,
    input wire logic [PRIO_W-1:0] lk_sa_prio,
    output logic fwd_valid,
    output logic [NPORT-1:0] fwd_map,
    output logic [PRIO_W-1:0] address_based_priority,
    output logic flush_start,
    output logic flush_stp,
    output logic [1:0] flush_scope,
    input wire logic flush_done,
    output logic age_tick
);
    // ==========================================================
    // apb decode
    logic [9:0] idx;
    logic sel1;
    logic sel2;
    logic sel3;
    logic mapped;
    logic setup;
    logic acc;
    logic wr1;
    logic wr2;
    logic wr3;

    assign idx = paddr[lep_pkg::ADDR_W-1:2];
    assign sel1 = (idx == lep_pkg::IDX_CTL1);
    assign sel2 = (idx == lep_pkg::IDX_CTL2);
    assign sel3 = (idx == lep_pkg::IDX_CTL3);
    assign mapped = sel1 || sel2 || sel3;
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr1 = acc && pwrite && sel1;
    assign wr2 = acc && pwrite && sel2;
    assign wr3 = acc && pwrite && sel3;
    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // ==========================================================
    // registers
    logic [7:0] ctl1_reg;
    logic [7:0] ctl2_reg;
    logic [7:0] ctl3_reg;
    logic [31:0] prdata_reg;
    lep_pkg::lep_flush_st_t fl_reg;
    logic trig_clr;
    logic scope_clr;
    logic [7:0] ctl1_wr;
    logic [7:0] trig_mask;

    assign trig_mask = 8'((1 << lep_pkg::C1_FLUSH_ALL)
        | (1 << lep_pkg::C1_FLUSH_STP));
    assign ctl1_wr = pwdata[7:0] & lep_pkg::CTL1_MASK;

    // triggers only add while idle; a write in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_reg <= lep_pkg::CTL1_RST;
        end else begin
            if (wr1) begin
                ctl1_reg <= (ctl1_wr & ~trig_mask)
                    | ((trig_clr ? 8'h00 : ctl1_reg) & trig_mask)
                    | ((fl_reg == lep_pkg::FL_IDLE || trig_clr)
                        ? (ctl1_wr & trig_mask) : 8'h00);
            end else if (trig_clr) begin
                ctl1_reg <= ctl1_reg & ~trig_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl2_reg <= lep_pkg::CTL2_RST;
        end else if (wr2) begin
            ctl2_reg <= pwdata[7:0];
        end else if (scope_clr) begin
            ctl2_reg[lep_pkg::C2_SCOPE_LSB +: 2] <= lep_pkg::SCOPE_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl3_reg <= lep_pkg::CTL3_RST;
        end else if (wr3) begin
            ctl3_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_reg <= {24'h00_0000,
                sel1 ? ctl1_reg : sel2 ? ctl2_reg
                : sel3 ? ctl3_reg : 8'h00};
        end
    end
    assign prdata = prdata_reg;

    // ==========================================================
    // flush sequencer
    logic trig_all;
    logic trig_stp;
    logic [1:0] scope;

    assign trig_all = ctl1_reg[lep_pkg::C1_FLUSH_ALL];
    assign trig_stp = ctl1_reg[lep_pkg::C1_FLUSH_STP];
    assign scope = ctl2_reg[lep_pkg::C2_SCOPE_LSB +: 2];
    // scope 00 at trigger time completes at once without a flush
    assign trig_clr = (fl_reg == lep_pkg::FL_IDLE && (trig_all || trig_stp)
        && scope == lep_pkg::SCOPE_NONE)
        || (fl_reg == lep_pkg::FL_BUSY && flush_done);
    assign scope_clr = fl_reg == lep_pkg::FL_BUSY && flush_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_reg <= lep_pkg::FL_IDLE;
        end else begin
            unique case (fl_reg)
                lep_pkg::FL_IDLE: begin
                    if ((trig_all || trig_stp)
                            && scope != lep_pkg::SCOPE_NONE) begin
                        fl_reg <= lep_pkg::FL_BUSY;
                    end
                end
                lep_pkg::FL_BUSY: begin
                    if (flush_done) begin
                        fl_reg <= lep_pkg::FL_IDLE;
                    end
                end
            endcase
        end
    end

    // whole table flush wins when both triggers are set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_start <= 1'b0;
            flush_stp <= 1'b0;
            flush_scope <= lep_pkg::SCOPE_NONE;
        end else begin
            flush_start <= 1'b0;
            if (fl_reg == lep_pkg::FL_IDLE && (trig_all || trig_stp)
                    && scope != lep_pkg::SCOPE_NONE) begin
                flush_start <= 1'b1;
                flush_stp <= !trig_all;
                flush_scope <= scope;
            end
        end
    end

    // ==========================================================
    // datapath helpers
    lep_cfg_if cfg ();
    assign cfg.mc_trap = ctl2_reg[lep_pkg::C2_TRAP];
    assign cfg.dyn_filt = ctl2_reg[lep_pkg::C2_DYN_FILT];
    assign cfg.sta_filt = ctl2_reg[lep_pkg::C2_STA_FILT];
    assign cfg.prio_sel = ctl2_reg[lep_pkg::C2_PRIO_LSB +: 2];
    assign cfg.age_en = ctl1_reg[lep_pkg::C1_AGE_EN];
    assign cfg.age_period = ctl3_reg;

    lep_fwd_sel #(
        .NPORT(NPORT),
        .PRIO_W(PRIO_W)
    ) u_fwd (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg),
        .lk_valid(lk_valid),
        .lk_hit(lk_hit),
        .lk_static(lk_static),
        .lk_rsv_mcast(lk_rsv_mcast),
        .dbl_tag_en(dbl_tag_en),
        .lk_entry_map(lk_entry_map),
        .lk_vlan_map(lk_vlan_map),
        .lk_da_prio(lk_da_prio),
        .lk_sa_prio(lk_sa_prio),
        .fwd_valid(fwd_valid),
        .fwd_map(fwd_map),
        .address_based_priority(address_based_priority)
    );

    // the tick drives aging of dynamic entries only
    lep_age_tick #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_age (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg),
        .age_tick(age_tick)
    );

    // ==========================================================
    // checks
    logic rst_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_filter_off: assert property (
        !rst_seen |-> ctl2_reg[lep_pkg::C2_DYN_FILT] == 1'b0
            && ctl2_reg[lep_pkg::C2_STA_FILT] == 1'b0)
        else $error("egress filter bits not clear after reset");
    a_reset_age_vals: assert property (
        !rst_seen |-> ctl3_reg == lep_pkg::CTL3_RST
            && ctl1_reg[lep_pkg::C1_AGE_EN])
        else $error("aging registers wrong after reset");
    a_flush_scope_live: assert property (
        flush_start |-> flush_scope != lep_pkg::SCOPE_NONE
            && flush_scope == $past(scope))
        else $error("flush started with wrong scope");
    a_flush_done_clear: assert property (
        fl_reg == lep_pkg::FL_BUSY && flush_done && !wr2 && !wr1
        |=> scope == lep_pkg::SCOPE_NONE && !trig_all && !trig_stp)
        else $error("flush completion did not clear field and trigger");
    a_trig_no_scope: assert property (
        fl_reg == lep_pkg::FL_IDLE && trig_all && !wr1 && !wr2
            && scope == lep_pkg::SCOPE_NONE
        |=> !trig_all ##1 !flush_start)
        else $error("trigger with scope 00 did not end at once");
    a_trigger_starts: assert property (
        fl_reg == lep_pkg::FL_IDLE && trig_all
            && scope != lep_pkg::SCOPE_NONE
        |=> flush_start && !flush_stp && fl_reg == lep_pkg::FL_BUSY)
        else $error("whole table flush not started");
    a_read_word: assert property (
        setup && !pwrite && sel3 ##1 acc |-> prdata == {24'h00_0000,
            $past(ctl3_reg)})
        else $error("read data of age period wrong");
    c_flush_run: cover property (flush_start ##[1:20] flush_done);
    c_stp_flush: cover property (flush_start && flush_stp);
endmodule

// File: bench/tb_top.sv
// self-checking bench for the lookup engine policy registers
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned SEC = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lk_valid = 1'b0;
    logic lk_hit = 1'b0;
    logic lk_static = 1'b0;
    logic lk_rsv_mcast = 1'b0;
    logic dbl_tag_en = 1'b0;
    logic [2:0] lk_entry_map = 3'h0;
    logic [2:0] lk_vlan_map = 3'h0;
    logic [2:0] lk_da_prio = 3'h0;
    logic [2:0] lk_sa_prio = 3'h0;
    logic fwd_valid;
    logic [2:0] fwd_map;
    logic [2:0] address_based_priority;
    logic flush_start;
    logic flush_stp;
    logic [1:0] flush_scope;
    logic flush_done = 1'b0;
    logic age_tick;
    integer failures = 0;
    integer samples_checked = 0;
    integer seed = 97454;
    integer starts = 0;
    integer ticks = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] c2;

    lep_regs_top #(.SEC_CYCLES(SEC)) u_lep_regs_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lk_valid(lk_valid),
        .lk_hit(lk_hit), .lk_static(lk_static),
        .lk_rsv_mcast(lk_rsv_mcast), .dbl_tag_en(dbl_tag_en),
        .lk_entry_map(lk_entry_map), .lk_vlan_map(lk_vlan_map),
        .lk_da_prio(lk_da_prio), .lk_sa_prio(lk_sa_prio),
        .fwd_valid(fwd_valid), .fwd_map(fwd_map),
        .address_based_priority(address_based_priority),
        .flush_start(flush_start), .flush_stp(flush_stp),
        .flush_scope(flush_scope), .flush_done(flush_done),
        .age_tick(age_tick)
    );

    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        if (flush_start === 1'b1) starts <= starts + 1;
        if (age_tick === 1'b1) ticks <= ticks + 1;
    end

    // ==========================================================
    // checking and closing
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        failures = failures + 1;
        end_of_test;
    end

    // ==========================================================
    // apb master: hold request until pready sampled high
    task automatic apb(input logic wr, input logic [9:0] idx,
        input logic [31:0] wd);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1);
        check("pready wait", n, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0);
        check("read data", rd, {24'h0, exp});
        check("read error", {31'h0, err}, 32'h0);
    endtask

    // ==========================================================
    // expected forwarding results
    function automatic logic [2:0] exp_map(input logic [7:0] c,
        input logic rsv, input logic dbl, input logic hit, input logic st,
        input logic [2:0] e, input logic [2:0] v);
        if (rsv && dbl && c[6]) return 3'h4;
        if (!hit) return v;
        if (st) return c[4] ? (e & v) : e;
        return c[5] ? (e & v) : e;
    endfunction

    function automatic logic [2:0] exp_prio(input logic [1:0] s,
        input logic [2:0] da, input logic [2:0] sa);
        case (s)
            2'h0: return da;
            2'h1: return sa;
            2'h2: return (da > sa) ? da : sa;
            default: return (da < sa) ? da : sa;
        endcase
    endfunction

    task automatic lookup;
        logic [31:0] r;
        r = $random(seed);
        @(posedge pclk);
        lk_valid <= 1'b1;
        lk_hit <= r[0];
        lk_static <= r[1];
        lk_rsv_mcast <= r[2];
        dbl_tag_en <= r[3];
        lk_entry_map <= r[6:4];
        lk_vlan_map <= r[9:7];
        lk_da_prio <= r[12:10];
        lk_sa_prio <= r[15:13];
        @(posedge pclk);
        lk_valid <= 1'b0;
        @(posedge pclk);
        check("fwd_valid", {31'h0, fwd_valid}, 32'h1);
        check("fwd_map", {29'h0, fwd_map}, {29'h0, exp_map(c2, r[2], r[3],
            r[0], r[1], r[6:4], r[9:7])});
        check("priority", {29'h0, address_based_priority},
            {29'h0, exp_prio(c2[1:0], r[12:10], r[15:13])});
        @(posedge pclk);
        check("fwd_valid low", {31'h0, fwd_valid}, 32'h0);
    endtask

    // ==========================================================
    // flush: one start per trigger, none for scope 00, scope cleared when done
    task automatic flush_case(input logic [1:0] scope, input logic stp);
        integer n0;
        integer n;
        logic [7:0] c1;
        c1 = stp ? 8'h14 : 8'h24;
        apb(1'b1, lep_pkg::IDX_CTL2, {28'h0, scope, 2'h0});
        apb(1'b1, lep_pkg::IDX_CTL1, {24'h0, c1});
        n0 = starts;
        if (scope == 2'h0) begin
            repeat (5) @(posedge pclk);
            rd_chk(lep_pkg::IDX_CTL1, 8'h04);
            check("no start", starts - n0, 32'h0);
            return;
        end
        n = 0;
        while (flush_start !== 1'b1) begin
            @(posedge pclk);
            n = n + 1;
        end
        check("start delay", n, 32'h2);
        check("flush_scope", {30'h0, flush_scope}, {30'h0, scope});
        check("flush_stp", {31'h0, flush_stp}, {31'h0, stp});
        // a repeated trigger while busy must not start a second flush
        apb(1'b1, lep_pkg::IDX_CTL1, {24'h0, c1});
        rd_chk(lep_pkg::IDX_CTL1, c1);
        check("one start", starts - n0, 32'h1);
        @(posedge pclk);
        flush_done <= 1'b1;
        @(posedge pclk);
        flush_done <= 1'b0;
        rd_chk(lep_pkg::IDX_CTL1, 8'h04);
        rd_chk(lep_pkg::IDX_CTL2, 8'h00);
        check("starts after done", starts - n0, 32'h1);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        integer i;
        integer n;
        integer t0;
        logic [7:0] v;
        c2 = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(lep_pkg::IDX_CTL1, 8'h04);
        rd_chk(lep_pkg::IDX_CTL2, 8'h00);
        rd_chk(lep_pkg::IDX_CTL3, 8'h4B);
        apb(1'b1, 10'h314, 32'h0000_00FF);
        check("unmapped write error", {31'h0, err}, 32'h1);
        apb(1'b0, 10'h314, 32'h0);
        check("unmapped read error", {31'h0, err}, 32'h1);
        check("unmapped read data", rd, 32'h0);
        for (i = 0; i < 32; i++) begin
            v = $random(seed);
            c2 = {v[7], i[4:2], 2'h0, i[1:0]};
            apb(1'b1, lep_pkg::IDX_CTL2, {24'h0, c2});
            rd_chk(lep_pkg::IDX_CTL2, c2);
            repeat (6) lookup;
        end
        for (i = 0; i < 8; i++) flush_case(i[1:0], i[2]);
        // aging: time between two ticks is the period times the unit
        v = $random(seed);
        apb(1'b1, lep_pkg::IDX_CTL3, {24'h0, v});
        rd_chk(lep_pkg::IDX_CTL3, v);
        apb(1'b1, lep_pkg::IDX_CTL3, 32'h0000_0003);
        for (i = 0; i < 2; i++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (age_tick !== 1'b1 && n < 200);
        end
        check("age period", n, 3 * SEC);
        apb(1'b1, lep_pkg::IDX_CTL1, 32'h0000_0000);
        // a tick launched at the disabling edge is still counted late
        repeat (2) @(posedge pclk);
        t0 = ticks;
        repeat (100) @(posedge pclk);
        check("ticks while off", ticks - t0, 32'h0);
        apb(1'b1, lep_pkg::IDX_CTL1, 32'h0000_0004);
        t0 = ticks;
        repeat (95) @(posedge pclk);
        check("ticks while on", ticks - t0, 32'h3);
        end_of_test;
    end
endmodule
